// ===== pkg/fdo_pkg.sv
/*
  Constants shared by the fail-safe digital output block: register map, field positions,
  reset values, fail-safe kinds, link states and timing.
  Assumes a single 100 MHz clock and an APB register slave with 32-bit data.
*/
// Function
// - Points readable, writable singly and packed
// - Four-point packed writes keep only low nibble
// - Communication loss forces committed fail-safe outputs
// - Kind 1 off, 2 pattern, 3 hold
// - Pattern bits drive points only kind 2
// - Wait committed delay in tenths first
// - Fail-safe settings staged until commit
// - Commit copies all three, self-clears
// - Fail-safe items write-only, points read/write
// - Eight-point variant, 255 sets all on
package fdo_pkg;

  // Timing
  localparam int CLK_PERIOD_NS       = 10;
  localparam int TENTH_NS            = 100_000_000;
  localparam int TENTH_CYCLES        = TENTH_NS / CLK_PERIOD_NS;
  localparam int COMM_TIMEOUT_TENTHS = 10;

  // Register byte addresses
  localparam logic [11:0] ADDR_OUT     = 12'h000;
  localparam logic [11:0] ADDR_KIND    = 12'h004;
  localparam logic [11:0] ADDR_MASK    = 12'h008;
  localparam logic [11:0] ADDR_DELAY   = 12'h00C;
  localparam logic [11:0] ADDR_COMMIT  = 12'h010;
  localparam logic [11:0] ADDR_STATUS  = 12'h014;
  localparam logic [11:0] ADDR_IRQEN   = 12'h018;
  localparam logic [11:0] ADDR_STATE   = 12'h01C;
  localparam logic [11:0] ADDR_PT_BASE = 12'h020;
  localparam logic [11:0] ADDR_PAT_BASE = 12'h040;

  // Fail-safe kinds
  localparam logic [7:0] KIND_OFF     = 8'h01;
  localparam logic [7:0] KIND_PATTERN = 8'h02;
  localparam logic [7:0] KIND_HOLD    = 8'h03;

  // Point masks of the two variants
  localparam logic [7:0] PT_MASK4 = 8'h0F;
  localparam logic [7:0] PT_MASK8 = 8'hFF;

  // Reset values
  localparam logic [7:0] KIND_RST  = KIND_OFF;
  localparam logic [7:0] MASK_RST  = 8'h00;
  localparam logic [7:0] DELAY_RST = 8'h00;
  localparam logic [7:0] OUT_RST   = 8'h00;

  // Status bit positions
  localparam int ST_FS_ENTER = 0;
  localparam int ST_RESTORE  = 1;
  localparam int ST_COMMIT   = 2;
  localparam int STAT_W      = 3;

  // Link supervision states
  typedef enum logic [1:0] {
    LINK_OK       = 2'b00,
    LINK_WAIT     = 2'b01,
    LINK_FAILSAFE = 2'b10
  } fdo_link_t;

endpackage

// ===== pkg/fdo_cfg_if.sv
/*
  Carrier between the register front end and the fail-safe configuration stage.
  Assumes both ends run on the same clock.
*/
`timescale 1ns/1ps
interface fdo_cfg_if;
  logic       wrKind;
  logic       wrMask;
  logic       wrPatBit;
  logic       wrDelay;
  logic       wrCommit;
  logic [2:0] patIdx;
  logic [7:0] wdata;
  logic [7:0] ptMask;
  logic [7:0] kind;
  logic [7:0] mask;
  logic [7:0] delay;
  logic       commitDone;

  modport host  (output wrKind, wrMask, wrPatBit, wrDelay, wrCommit, patIdx, wdata, ptMask,
                 input kind, mask, delay, commitDone);
  modport stage (input wrKind, wrMask, wrPatBit, wrDelay, wrCommit, patIdx, wdata, ptMask,
                 output kind, mask, delay, commitDone);
endinterface

// ===== verilog/fdo_tenth_tick.sv
/*
  Tenth-of-a-second tick divider with restart.
  Assumes restart comes from logic on the same clock.
*/
`timescale 1ns/1ps
module fdo_tenth_tick #(
  parameter int CYCLES = fdo_pkg::TENTH_CYCLES
)(
  input  wire logic mclk,
  input  wire logic rst_n,
  input  wire logic restart,
  output logic      tick
);
  logic [23:0] cnt_r;
  logic        tick_r;

  // Count one tenth, restart phase on host traffic
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_r  <= 24'h000000;
      tick_r <= 1'b0;
    end else if (restart) begin
      cnt_r  <= 24'h000000;
      tick_r <= 1'b0;
    end else if (cnt_r == 24'(CYCLES - 1)) begin
      cnt_r  <= 24'h000000;
      tick_r <= 1'b1;
    end else begin
      cnt_r  <= cnt_r + 24'h000001;
      tick_r <= 1'b0;
    end
  end

  assign tick = tick_r;
endmodule

// ===== verilog/fdo_fs_cfg.sv
/*
  Staged and committed fail-safe configuration.
  Assumes write strobes are one-cycle pulses from the register front end.
*/
`timescale 1ns/1ps
module fdo_fs_cfg (
  input wire logic mclk,
  input wire logic rst_n,
  fdo_cfg_if.stage cfg
);
  logic [7:0] stKind_r;
  logic [7:0] stMask_r;
  logic [7:0] stDelay_r;
  logic [7:0] kind_r;
  logic [7:0] mask_r;
  logic [7:0] delay_r;
  logic       done_r;
  logic       commit;

  assign commit = cfg.wrCommit & cfg.wdata[0]; // Writing false does nothing

  // Staging registers
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      stKind_r  <= fdo_pkg::KIND_RST;
      stMask_r  <= fdo_pkg::MASK_RST;
      stDelay_r <= fdo_pkg::DELAY_RST;
    end else begin
      if (cfg.wrKind) stKind_r <= cfg.wdata;
      if (cfg.wrMask) stMask_r <= cfg.wdata & cfg.ptMask;
      if (cfg.wrPatBit) stMask_r[cfg.patIdx] <= cfg.wdata[0];
      if (cfg.wrDelay) stDelay_r <= cfg.wdata;
    end
  end

  // Committed copy, all three at once
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      kind_r  <= fdo_pkg::KIND_RST;
      mask_r  <= fdo_pkg::MASK_RST;
      delay_r <= fdo_pkg::DELAY_RST;
      done_r  <= 1'b0;
    end else begin
      done_r <= commit; // Commit bit clears itself
      if (commit) begin
        kind_r  <= stKind_r;
        mask_r  <= stMask_r;
        delay_r <= stDelay_r;
      end
    end
  end

  assign cfg.kind       = kind_r;
  assign cfg.mask       = mask_r;
  assign cfg.delay      = delay_r;
  assign cfg.commitDone = done_r;
endmodule

// ===== verilog/fdo_top.sv
/*
  Fail-safe digital output block: APB register slave, commanded points, host-loss
  supervision, fail-safe output forcing and interrupt.
  Assumes APB signals come from logic on mclk; points drive external output stages.
*/
`timescale 1ns/1ps
module fdo_top #(
  parameter int TENTH_CYCLES        = fdo_pkg::TENTH_CYCLES,
  parameter int COMM_TIMEOUT_TENTHS = fdo_pkg::COMM_TIMEOUT_TENTHS,
  parameter bit EIGHT_POINTS        = 1'b0
)(
  input  wire logic        mclk,
  input  wire logic        rst_n,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  output logic      [7:0]  points,
  output logic             irq
);
  localparam logic [7:0] PT_MASK = EIGHT_POINTS ? fdo_pkg::PT_MASK8 : fdo_pkg::PT_MASK4;
  localparam int ZERO_DELAY_MAX = 2;
  localparam int READ_LAT = 1;

  logic [31:0]             prdata_r;
  logic                    pready_r;
  logic                    pslverr_r;
  logic [7:0]              pointsOut_r;
  logic                    irq_r;
  logic [7:0]              outCmd_r;
  logic [fdo_pkg::STAT_W-1:0] status_r;
  logic [fdo_pkg::STAT_W-1:0] irqEn_r;
  logic [fdo_pkg::STAT_W-1:0] events;
  logic [15:0]             idle_r;
  logic [7:0]              delayCnt_r;
  fdo_pkg::fdo_link_t      state_r;
  logic                    setup;
  logic                    xfer;
  logic                    wrXfer;
  logic                    hit;
  logic [31:0]             rdVal;
  logic                    tick;
  logic                    lossNow;
  logic                    fsEnter;
  logic                    wrOut;
  logic                    wrPt;
  logic                    wrStat;
  logic                    wrIrqEn;
  logic [2:0]              idx;

  fdo_cfg_if cfgIf ();

  // Is the address one word of a per-point bank that this variant has
  function automatic logic inBank(input logic [11:0] a, input logic [11:0] base);
    logic [11:0] off;
    off = a - base;
    return (a >= base) && (off[11:5] == 7'h00) && (off[1:0] == 2'h0) && PT_MASK[off[4:2]];
  endfunction

  // Point number of a per-point bank address
  function automatic logic [2:0] bankIdx(input logic [11:0] a, input logic [11:0] base);
    logic [11:0] off;
    off = a - base;
    return off[4:2];
  endfunction

  // APB phases; every completed access counts as host traffic
  assign setup  = psel & ~penable;
  assign xfer   = psel & penable & pready_r;
  assign wrXfer = xfer & pwrite & ~pslverr_r;

  // Read mux and address decode
  always_comb begin
    hit   = 1'b1;
    rdVal = 32'h00000000;
    idx   = 3'h0;
    if (paddr == fdo_pkg::ADDR_OUT) begin
      rdVal = {24'h000000, outCmd_r};
    end else if (paddr == fdo_pkg::ADDR_KIND || paddr == fdo_pkg::ADDR_MASK) begin
      rdVal = 32'h00000000;
    end else if (paddr == fdo_pkg::ADDR_DELAY || paddr == fdo_pkg::ADDR_COMMIT) begin
      rdVal = 32'h00000000;
    end else if (paddr == fdo_pkg::ADDR_STATUS) begin
      rdVal = {29'h00000000, status_r};
    end else if (paddr == fdo_pkg::ADDR_IRQEN) begin
      rdVal = {29'h00000000, irqEn_r};
    end else if (paddr == fdo_pkg::ADDR_STATE) begin
      rdVal = {28'h0000000, EIGHT_POINTS, 1'b0, state_r};
    end else if (inBank(paddr, fdo_pkg::ADDR_PT_BASE)) begin
      idx   = bankIdx(paddr, fdo_pkg::ADDR_PT_BASE);
      rdVal = {31'h00000000, outCmd_r[idx]};
    end else if (inBank(paddr, fdo_pkg::ADDR_PAT_BASE)) begin
      idx   = bankIdx(paddr, fdo_pkg::ADDR_PAT_BASE);
      rdVal = 32'h00000000;
    end else begin
      hit = 1'b0;
    end
  end

  // Write strobes, valid only at the completing edge
  assign wrOut   = wrXfer && paddr == fdo_pkg::ADDR_OUT;
  assign wrPt    = wrXfer && inBank(paddr, fdo_pkg::ADDR_PT_BASE);
  assign wrStat  = wrXfer && paddr == fdo_pkg::ADDR_STATUS;
  assign wrIrqEn = wrXfer && paddr == fdo_pkg::ADDR_IRQEN;
  assign cfgIf.wrKind   = wrXfer && paddr == fdo_pkg::ADDR_KIND;
  assign cfgIf.wrMask   = wrXfer && paddr == fdo_pkg::ADDR_MASK;
  assign cfgIf.wrDelay  = wrXfer && paddr == fdo_pkg::ADDR_DELAY;
  assign cfgIf.wrCommit = wrXfer && paddr == fdo_pkg::ADDR_COMMIT;
  assign cfgIf.wrPatBit = wrXfer && inBank(paddr, fdo_pkg::ADDR_PAT_BASE);
  assign cfgIf.patIdx   = idx;
  assign cfgIf.wdata    = pwdata[7:0];
  assign cfgIf.ptMask   = PT_MASK;

  fdo_fs_cfg u_cfg (
    .mclk  (mclk),
    .rst_n (rst_n),
    .cfg   (cfgIf.stage)
  );

  fdo_tenth_tick #(
    .CYCLES (TENTH_CYCLES)
  ) u_tick (
    .mclk    (mclk),
    .rst_n   (rst_n),
    .restart (xfer),
    .tick    (tick)
  );

  // APB answer: one access cycle, data and error latched at setup
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      pready_r  <= 1'b0;
      pslverr_r <= 1'b0;
      prdata_r  <= 32'h00000000;
    end else begin
      pready_r  <= setup;
      pslverr_r <= setup & ~hit;
      prdata_r  <= (setup && !pwrite && hit) ? rdVal : 32'h00000000;
    end
  end

  // Host-commanded point values
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      outCmd_r <= fdo_pkg::OUT_RST;
    end else if (wrOut) begin
      outCmd_r <= pwdata[7:0] & PT_MASK;
    end else if (wrPt) begin
      outCmd_r[idx] <= pwdata[0];
    end
  end

  // Idle time since last host access, in tenths
  assign lossNow = (state_r == fdo_pkg::LINK_OK) && !xfer &&
                   (idle_r >= 16'(COMM_TIMEOUT_TENTHS));
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      idle_r <= 16'h0000;
    end else if (xfer) begin
      idle_r <= 16'h0000;
    end else if (tick && idle_r != 16'hFFFF) begin
      idle_r <= idle_r + 16'h0001;
    end
  end

  // Link supervision: ok, waiting out the delay, fail-safe
  assign fsEnter = (state_r == fdo_pkg::LINK_WAIT) && !xfer && (delayCnt_r == 8'h00);
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      state_r    <= fdo_pkg::LINK_OK;
      delayCnt_r <= 8'h00;
    end else begin
      case (state_r)
        fdo_pkg::LINK_OK: begin
          if (lossNow) begin
            state_r    <= fdo_pkg::LINK_WAIT;
            delayCnt_r <= cfgIf.delay;
          end
        end
        fdo_pkg::LINK_WAIT: begin
          if (xfer) begin
            state_r <= fdo_pkg::LINK_OK;
          end else if (delayCnt_r == 8'h00) begin
            state_r <= fdo_pkg::LINK_FAILSAFE;
          end else if (tick) begin
            delayCnt_r <= delayCnt_r - 8'h01;
          end
        end
        fdo_pkg::LINK_FAILSAFE: begin
          if (xfer) begin
            state_r <= fdo_pkg::LINK_OK;
          end
        end
        default: begin
          state_r <= fdo_pkg::LINK_OK;
        end
      endcase
    end
  end

  // Point drive: commanded values, or the committed fail-safe choice
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      pointsOut_r <= fdo_pkg::OUT_RST;
    end else if (state_r == fdo_pkg::LINK_FAILSAFE) begin
      case (cfgIf.kind)
        fdo_pkg::KIND_PATTERN: pointsOut_r <= cfgIf.mask & PT_MASK;
        fdo_pkg::KIND_HOLD:    pointsOut_r <= pointsOut_r;
        default:               pointsOut_r <= 8'h00;
      endcase
    end else begin
      pointsOut_r <= outCmd_r;
    end
  end

  // Sticky events, set wins over a one-to-clear write
  assign events = {cfgIf.commitDone,
                   (state_r != fdo_pkg::LINK_OK) && xfer,
                   fsEnter};
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      status_r <= 3'h0;
    end else begin
      status_r <= (status_r & ~(wrStat ? pwdata[2:0] : 3'h0)) | events;
    end
  end

  // Interrupt enables and level output
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      irqEn_r <= 3'h0;
      irq_r   <= 1'b0;
    end else begin
      if (wrIrqEn) irqEn_r <= pwdata[2:0];
      irq_r <= |(status_r & irqEn_r);
    end
  end

  assign prdata  = prdata_r;
  assign pready  = pready_r;
  assign pslverr = pslverr_r;
  assign points  = pointsOut_r;
  assign irq     = irq_r;

  // Checks
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);

  property p_packed_write;
    wrOut |=> outCmd_r == ($past(pwdata[7:0]) & PT_MASK);
  endproperty
  a_packed_write: assert property (p_packed_write) else $error("packed write lost");

  property p_nibble_only;
    !EIGHT_POINTS |-> (outCmd_r[7:4] == 4'h0 && pointsOut_r[7:4] == 4'h0);
  endproperty
  a_nibble_only: assert property (p_nibble_only) else $error("high points set");

  property p_kind_off;
    (state_r == fdo_pkg::LINK_FAILSAFE && cfgIf.kind == fdo_pkg::KIND_OFF)
      |=> pointsOut_r == 8'h00;
  endproperty
  a_kind_off: assert property (p_kind_off) else $error("fail-safe off failed");

  property p_kind_hold;
    (state_r == fdo_pkg::LINK_FAILSAFE && cfgIf.kind == fdo_pkg::KIND_HOLD)
      |=> $stable(pointsOut_r);
  endproperty
  a_kind_hold: assert property (p_kind_hold) else $error("hold not held");

  property p_pattern;
    (state_r == fdo_pkg::LINK_FAILSAFE && cfgIf.kind == fdo_pkg::KIND_PATTERN)
      |=> pointsOut_r == ($past(cfgIf.mask) & PT_MASK);
  endproperty
  a_pattern: assert property (p_pattern) else $error("pattern not applied");

  sequence s_loss_no_delay;
    lossNow && cfgIf.delay == 8'h00;
  endsequence
  sequence s_quiet_fs;
    !xfer [*2];
  endsequence
  property p_zero_delay;
    s_loss_no_delay ##0 s_quiet_fs |-> ##[1:ZERO_DELAY_MAX] state_r == fdo_pkg::LINK_FAILSAFE;
  endproperty
  a_zero_delay: assert property (p_zero_delay) else $error("zero delay late");

  property p_staged_only;
    (cfgIf.wrKind || cfgIf.wrMask || cfgIf.wrDelay) |=> $stable(cfgIf.kind) &&
      $stable(cfgIf.mask) && $stable(cfgIf.delay);
  endproperty
  a_staged_only: assert property (p_staged_only) else $error("staged write applied");

  property p_commit_pulse;
    cfgIf.wrCommit && pwdata[0] |=> cfgIf.commitDone ##1 !cfgIf.commitDone;
  endproperty
  a_commit_pulse: assert property (p_commit_pulse) else $error("commit not one pulse");

  property p_wo_read;
    (setup && !pwrite && (paddr == fdo_pkg::ADDR_KIND || paddr == fdo_pkg::ADDR_COMMIT))
      |-> ##READ_LAT prdata_r == 32'h00000000;
  endproperty
  a_wo_read: assert property (p_wo_read) else $error("write-only reads back");

  property p_restore;
    (state_r == fdo_pkg::LINK_FAILSAFE && xfer) |=> state_r == fdo_pkg::LINK_OK
      ##1 pointsOut_r == $past(outCmd_r);
  endproperty
  a_restore: assert property (p_restore) else $error("link not restored");

  // Answer comes in the cycle after every setup
  property p_ready;
    setup |=> pready_r;
  endproperty
  a_ready: assert property (p_ready) else $error("no ready after setup");

  // Fail-safe entry sets its sticky bit and the state together
  property p_fs_event;
    fsEnter |=> status_r[fdo_pkg::ST_FS_ENTER] && state_r == fdo_pkg::LINK_FAILSAFE;
  endproperty
  a_fs_event: assert property (p_fs_event) else $error("fail-safe entry lost");

  // Delay counts down one step per tenth while waiting
  property p_delay_step;
    (state_r == fdo_pkg::LINK_WAIT && !xfer && tick && delayCnt_r != 8'h00)
      |=> delayCnt_r == $past(delayCnt_r) - 8'h01;
  endproperty
  a_delay_step: assert property (p_delay_step) else $error("delay step lost");

  // Interrupt follows the unmasked status one cycle later
  property p_irq_level;
    1'b1 |=> irq_r == |($past(status_r) & $past(irqEn_r));
  endproperty
  a_irq_level: assert property (p_irq_level) else $error("irq not level");

  // A host access while not ok is logged as a restore
  property p_restore_event;
    (state_r != fdo_pkg::LINK_OK && xfer) |=> status_r[fdo_pkg::ST_RESTORE];
  endproperty
  a_restore_event: assert property (p_restore_event) else $error("restore lost");

endmodule

// ===== tb/fdo_host_model.sv
/*
  Host controller model: APB master that polls the output block.
  Assumes one clock shared with the block; tasks are called at a rising edge.
*/
`timescale 1ns/1ps
module fdo_host_model (
  input  wire logic        mclk,
  output logic             psel,
  output logic             penable,
  output logic             pwrite,
  output logic      [11:0] paddr,
  output logic      [31:0] pwdata,
  input  wire logic [31:0] prdata,
  input  wire logic        pready,
  input  wire logic        pslverr
);
  // Bus idle from time zero
  initial begin
    psel    = 1'b0;
    penable = 1'b0;
    pwrite  = 1'b0;
    paddr   = 12'h000;
    pwdata  = 32'h0000_0000;
  end

  // One transfer; an idle edge first so no signal is assigned twice in a step
  task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d,
                      output logic [31:0] r, output logic e);
    @(posedge mclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge mclk);
    penable <= 1'b1;
    @(posedge mclk);
    // Request held until pready is seen high
    while (pready !== 1'b1) begin
      @(posedge mclk);
    end
    r = prdata;
    e = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask
endmodule

// ===== tb/tb.sv
/*
  Testbench of the fail-safe output block: register access, host loss, fail-safe kinds,
  delay, commit staging and interrupt.
  Assumes short tenth and timeout parameters so the run stays brief.
*/
`timescale 1ns/1ps
module tb;
  logic        mclk;
  logic        rst_n;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [11:0] paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic [7:0]  points;
  logic [7:0]  points8;
  logic        irq;
  logic [31:0] rdv;
  logic        errv;
  int          mismatches;
  int          compares;

  // Four-point block under test
  fdo_top #(.TENTH_CYCLES(10), .COMM_TIMEOUT_TENTHS(2)) fdo_top_inst (
    .mclk(mclk), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .points(points), .irq(irq));

  // Eight-point variant on the same bus; only its points are watched
  fdo_top #(.TENTH_CYCLES(10), .COMM_TIMEOUT_TENTHS(2), .EIGHT_POINTS(1'b1)) fdo_top_inst8 (
    .mclk(mclk), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(), .pready(), .pslverr(),
    .points(points8), .irq());

  fdo_host_model fdo_host_model_inst (
    .mclk(mclk), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));

  // Clock of 10 ns
  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end

  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      mismatches++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    fdo_host_model_inst.xfer(1'b1, a, d, rdv, errv);
  endtask

  task automatic rd(input logic [11:0] a);
    fdo_host_model_inst.xfer(1'b0, a, 32'h0000_0000, rdv, errv);
  endtask

  task automatic idle(input int n);
    repeat (n) @(posedge mclk);
  endtask

  task automatic results();
    $display("compares %0d mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  // Watchdog against a hang
  initial begin
    idle(5000);
    mismatches++;
    results();
  end

  // Main sequence
  initial begin
    mismatches = 0;
    compares   = 0;
    rst_n      = 1'b0;
    idle(3);
    rst_n <= 1'b1;
    idle(1);
    check("points", {24'h0, points}, 32'h0);
    check("irq", {31'h0, irq}, 32'h0);
    // Packed writes, cropping and variants
    wr(fdo_pkg::ADDR_OUT, 32'h0000_00FF);
    idle(2);
    check("points8", {24'h0, points8}, 32'hFF);
    check("points", {24'h0, points}, 32'h0F);
    wr(fdo_pkg::ADDR_OUT, 32'h0000_03A5);
    idle(2);
    check("points", {24'h0, points}, 32'h05);
    wr(fdo_pkg::ADDR_PT_BASE + 12'h00C, 32'h1);
    rd(fdo_pkg::ADDR_OUT);
    check("packed", rdv, 32'hD);
    rd(fdo_pkg::ADDR_PT_BASE + 12'h004);
    check("point1", rdv, 32'h0);
    rd(fdo_pkg::ADDR_PT_BASE + 12'h008);
    check("point2", rdv, 32'h1);
    rd(fdo_pkg::ADDR_PT_BASE + 12'h010);
    check("point4 err", {31'h0, errv}, 32'h1);
    rd(fdo_pkg::ADDR_KIND);
    check("kind read", rdv, 32'h0);
    // Default fail-safe after loss: all off, then traffic restores
    idle(40);
    check("fs default", {24'h0, points}, 32'h0);
    rd(fdo_pkg::ADDR_STATE);
    check("state fs", rdv, 32'h2);
    idle(3);
    check("restored", {24'h0, points}, 32'hD);
    // Staged settings have no effect before commit
    wr(fdo_pkg::ADDR_KIND, 32'h2);
    wr(fdo_pkg::ADDR_MASK, 32'hFA);
    wr(fdo_pkg::ADDR_PAT_BASE, 32'h1);
    idle(40);
    check("staged", {24'h0, points}, 32'h0);
    wr(fdo_pkg::ADDR_COMMIT, 32'h1);
    rd(fdo_pkg::ADDR_COMMIT);
    check("commit", rdv, 32'h0);
    idle(40);
    check("pattern", {24'h0, points}, 32'hB);
    // Commit written as zero does nothing
    wr(fdo_pkg::ADDR_KIND, 32'h3);
    wr(fdo_pkg::ADDR_COMMIT, 32'h0);
    idle(40);
    check("commit0", {24'h0, points}, 32'hB);
    wr(fdo_pkg::ADDR_COMMIT, 32'h1);
    wr(fdo_pkg::ADDR_OUT, 32'h6);
    idle(40);
    check("hold", {24'h0, points}, 32'h6);
    // Delay of three tenths, interrupt masked
    wr(fdo_pkg::ADDR_KIND, 32'h1);
    wr(fdo_pkg::ADDR_DELAY, 32'h3);
    wr(fdo_pkg::ADDR_COMMIT, 32'h1);
    idle(46);
    check("delay wait", {24'h0, points}, 32'h6);
    idle(19);
    check("delay done", {24'h0, points}, 32'h0);
    check("irq masked", {31'h0, irq}, 32'h0);
    // Interrupt raised, cleared, raised again
    wr(fdo_pkg::ADDR_IRQEN, 32'h1);
    idle(2);
    check("irq on", {31'h0, irq}, 32'h1);
    rd(fdo_pkg::ADDR_STATUS);
    check("status", rdv, 32'h7);
    wr(fdo_pkg::ADDR_STATUS, 32'h7);
    idle(2);
    check("irq clr", {31'h0, irq}, 32'h0);
    rd(fdo_pkg::ADDR_STATUS);
    check("status clr", rdv, 32'h0);
    idle(70);
    check("irq again", {31'h0, irq}, 32'h1);
    // Reset in mid-run brings back the default committed settings
    rst_n <= 1'b0;
    idle(3);
    rst_n <= 1'b1;
    idle(1);
    check("rst points", {24'h0, points}, 32'h0);
    check("rst irq", {31'h0, irq}, 32'h0);
    wr(fdo_pkg::ADDR_OUT, 32'hF);
    idle(2);
    check("rst out", {24'h0, points}, 32'hF);
    idle(28);
    check("rst delay", {24'h0, points}, 32'h0);
    results();
  end
endmodule
